// ### hdl/wsc_pkg.sv
/*
  Constants of the wake source configuration bank: register addresses,
  field positions, writable masks, reset and forced values, serial frame
  layout. Assumes a 16-bit serial frame of 7 address bits, one
  direction bit and 8 data bits, most significant bit first.
*/
package wsc_pkg;

  localparam int unsigned REG_W   = 8;
  localparam int unsigned ADDR_W  = 7;
  localparam int unsigned FRAME_W = 16;
  localparam int unsigned CNT_W   = 5;

  // register addresses
  localparam logic [ADDR_W-1:0] ADDR_INTERNAL_WAKE = 7'h06;
  localparam logic [ADDR_W-1:0] ADDR_EXTERNAL_WAKE = 7'h07;
  localparam logic [ADDR_W-1:0] ADDR_PULL_CONTROL  = 7'h08;

  // internal wake control fields
  localparam int unsigned BIT_SECOND_TIMER_WAKE = 7;
  localparam int unsigned BIT_FIRST_TIMER_WAKE  = 6;
  localparam int unsigned BIT_STOP_WD_OFF       = 2;

  // external wake source control fields
  localparam int unsigned BIT_INT_GLOBAL   = 7;
  localparam int unsigned BIT_MEASURE      = 5;
  localparam int unsigned BIT_THIRD_WAKE   = 2;
  localparam int unsigned BIT_SECOND_WAKE  = 1;
  localparam int unsigned BIT_FIRST_WAKE   = 0;

  // pull control fields, low bit of each two-bit field
  localparam int unsigned POS_THIRD_PULL  = 4;
  localparam int unsigned POS_SECOND_PULL = 2;
  localparam int unsigned POS_FIRST_PULL  = 0;

  // writable bits; everything else is reserved and reads zero
  localparam logic [REG_W-1:0] WMASK_INTERNAL = 8'hc4;
  localparam logic [REG_W-1:0] WMASK_EXTERNAL = 8'ha7;
  localparam logic [REG_W-1:0] WMASK_PULL     = 8'h3f;

  localparam logic [REG_W-1:0] RST_INTERNAL = 8'h00;
  localparam logic [REG_W-1:0] RST_EXTERNAL = 8'h07;
  localparam logic [REG_W-1:0] RST_PULL     = 8'h00;

  localparam logic [REG_W-1:0] MASK_ALL  = 8'hff;
  localparam logic [REG_W-1:0] MASK_NONE = 8'h00;

  // restart clears all but the two timer enables
  localparam logic [REG_W-1:0] RESTART_MASK_INTERNAL = 8'h3f;
  localparam logic [REG_W-1:0] RESTART_VAL_INTERNAL  = 8'h00;

  // fail-safe entry: external control bit 7 kept, bits 6..0 to 0000111
  localparam logic [REG_W-1:0] FAILSAFE_MASK_EXTERNAL = 8'h7f;
  localparam logic [REG_W-1:0] FAILSAFE_VAL_EXTERNAL  = 8'h07;

  // fail-safe entry: bus control low five bits to 0_1001
  localparam int unsigned      BUS_FORCE_W   = 5;
  localparam logic [BUS_FORCE_W-1:0] FAILSAFE_VAL_BUS = 5'h09;

  localparam logic [REG_W-1:0] READ_UNMAPPED = 8'h00;

  // frame: bits 15:9 address, bit 8 direction (1 = write), 7:0 data
  localparam int unsigned POS_RW       = 8;
  localparam int unsigned POS_ADDR_LSB = 9;
  localparam logic [CNT_W-1:0] CNT_ADDR_DONE = 5'h07;
  localparam logic [CNT_W-1:0] CNT_HEAD_DONE = 5'h08;
  localparam logic [CNT_W-1:0] CNT_FRAME     = 5'h10;
  localparam logic [CNT_W-1:0] CNT_SAT       = 5'h1f;

endpackage

// ### hdl/wsc_load_if.sv
/*
  Hardware load bundle for one configuration register: a strobe plus a
  bit mask and the value for the masked bits.
  Assumes one driver per register and a single clock domain.
*/
`timescale 1ns/1ns
interface wsc_load_if #(
  parameter int unsigned WIDTH = 8
);
  logic             ld;
  logic [WIDTH-1:0] mask;
  logic [WIDTH-1:0] value;

  modport drive (output ld, output mask, output value);
  modport take  (input ld, input mask, input value);
endinterface

// ### hdl/wsc_reg_cell.sv
/*
  One configuration register with software write, masked hardware load
  and reserved bits held at zero.
  Assumes write and load strobes are one-cycle pulses on clk.
*/
`timescale 1ns/1ns
module wsc_reg_cell #(
  parameter int unsigned     WIDTH       = 8,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0,
  parameter logic [WIDTH-1:0] WRITE_MASK  = '1
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             wr,
  input  wire logic [WIDTH-1:0] wdata,
  wsc_load_if.take              load,
  output      logic [WIDTH-1:0] q
);

  if (WIDTH < 1) begin : g_chk
    $error("wsc_reg_cell: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] next_q;

  // hardware load wins over a software write in the same cycle
  assign next_q = load.ld ? (((q & ~load.mask) | (load.value & load.mask)) & WRITE_MASK)
                : wr      ? (wdata & WRITE_MASK)
                :           q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= RESET_VALUE;
    end else begin
      q <= next_q;
    end
  end

endmodule

// ### hdl/wsc_wake_resolve.sv
/*
  Resolves the external wake control register into the effective wake
  enables of the three inputs and the measurement enable.
  Assumes normal_mode is synchronous to clk.
*/
`timescale 1ns/1ns
module wsc_wake_resolve #(
  parameter int unsigned INPUTS = 3
) (
  input  wire logic                      clk,
  input  wire logic                      reset_n,
  input  wire logic [wsc_pkg::REG_W-1:0] ext_ctrl,
  input  wire logic                      normal_mode,
  output      logic [INPUTS-1:0]         wake_enable,
  output      logic                      measure_enable
);

  if (INPUTS != 3) begin : g_chk
    $error("wsc_wake_resolve: exactly three wake inputs are supported");
  end

  logic              meas_sel;
  logic [INPUTS-1:0] next_wake_enable;
  logic              next_measure_enable;

  assign meas_sel = ext_ctrl[wsc_pkg::BIT_MEASURE];
  // measurement owns the first two inputs, so their enables are ignored
  assign next_wake_enable[0] = ext_ctrl[wsc_pkg::BIT_FIRST_WAKE] & ~meas_sel;
  assign next_wake_enable[1] = ext_ctrl[wsc_pkg::BIT_SECOND_WAKE] & ~meas_sel;
  assign next_wake_enable[2] = ext_ctrl[wsc_pkg::BIT_THIRD_WAKE];
  assign next_measure_enable = meas_sel & normal_mode;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wake_enable    <= '0;
      measure_enable <= 1'b0;
    end else begin
      wake_enable    <= next_wake_enable;
      measure_enable <= next_measure_enable;
    end
  end

endmodule

// ### hdl/wsc_wake_config.sv
/*
  Wake source configuration bank: serial configuration port slave, the
  internal wake, external wake source and wake input pull registers,
  fail-safe and restart handling, and the interrupt scope gate.
  Assumes all inputs, the serial port pins included, are synchronous to
  clk, and that the serial clock is slow enough that each level lasts
  at least two clk cycles.
*/
`timescale 1ns/1ns

// Notes on behaviour
// - bit 7 of internal wake control enables the second timer as wake source.
// - bit 6 of internal wake control enables the first timer as wake source.
// - reserved bits of every wake register always read back zero.
// - bit 2 turns the watchdog off in stop mode; hardware may also update it.
// - external bit 7 set lets every status bit raise interrupt, else only wakes.
// - measure select ignores first two input wake enables; measures in normal mode.
// - external bits 2..0 enable third, second, first input as wake sources.
// - fail-safe entry forces bus control to xxx0_1001 and external to x0000111.
// - two-bit pull fields: none, pull-down, pull-up, automatic; at 5:4, 3:2, 1:0.
// - restart keeps the timer wake enables and clears the rest of internal control.
// - power-on or soft reset sets external control to 0000_0111.
module wsc_wake_config (
  input  wire logic                            clk,
  input  wire logic                            reset_n,
  input  wire logic                            spi_csn_n,
  input  wire logic                            spi_clk,
  input  wire logic                            spi_sdi,
  output      logic                            spi_sdo,
  output      logic                            spi_sdo_en,
  input  wire logic                            soft_reset_req,
  input  wire logic                            restart_entry,
  input  wire logic                            fail_safe_entry,
  input  wire logic                            wd_off_update,
  input  wire logic                            wd_off_value,
  input  wire logic                            normal_mode,
  input  wire logic                            wake_event,
  input  wire logic                            status_event,
  output      logic                            second_timer_wake_enable,
  output      logic                            first_timer_wake_enable,
  output      logic                            stop_mode_watchdog_off_bit,
  output      logic                            interrupt_scope_all,
  output      logic                            first_hv_wake_input_enable,
  output      logic                            second_hv_wake_input_enable,
  output      logic                            third_hv_wake_input_enable,
  output      logic                            measure_enable,
  output      logic [1:0]                      first_input_pull_select,
  output      logic [1:0]                      second_input_pull_select,
  output      logic [1:0]                      third_input_pull_select,
  output      logic                            int_request,
  output      logic                            bus_ctrl_force,
  output      logic [wsc_pkg::BUS_FORCE_W-1:0] bus_ctrl_force_value
);

  localparam int unsigned W = wsc_pkg::REG_W;

  // serial port state
  logic                        sclk_q;
  logic                        csn_q;
  logic [wsc_pkg::CNT_W-1:0]   bit_cnt;
  logic [wsc_pkg::FRAME_W-1:0] shift_in;
  logic [wsc_pkg::ADDR_W-1:0]  frame_addr;
  logic [W-1:0]                tx_shift;
  logic [W-1:0]                rd_data;
  logic                        reg_wr;
  logic [wsc_pkg::ADDR_W-1:0]  wr_addr;
  logic [W-1:0]                wr_data;

  logic sclk_rise;
  logic sclk_fall;
  logic frame_end;
  logic frame_write;
  logic in_frame;
  logic cnt_at_sat;

  assign in_frame    = ~spi_csn_n;
  assign sclk_rise   = in_frame & spi_clk & ~sclk_q;
  assign sclk_fall   = in_frame & ~spi_clk & sclk_q;
  assign frame_end   = spi_csn_n & ~csn_q;
  assign cnt_at_sat  = (bit_cnt == wsc_pkg::CNT_SAT);
  // a frame of any other length than sixteen bits is dropped
  assign frame_write = frame_end & (bit_cnt == wsc_pkg::CNT_FRAME) & shift_in[wsc_pkg::POS_RW];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sclk_q <= 1'b0;
      csn_q  <= 1'b1;
    end else begin
      sclk_q <= spi_clk;
      csn_q  <= spi_csn_n;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bit_cnt  <= '0;
      shift_in <= '0;
    end else if (!in_frame) begin
      bit_cnt  <= '0;
    end else if (sclk_rise) begin
      shift_in <= {shift_in[wsc_pkg::FRAME_W-2:0], spi_sdi};
      bit_cnt  <= cnt_at_sat ? bit_cnt : bit_cnt + 1'b1;
    end
  end

  // address is complete on the seventh rising edge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      frame_addr <= '0;
    end else if (sclk_rise && bit_cnt == (wsc_pkg::CNT_ADDR_DONE - 1'b1)) begin
      frame_addr <= {shift_in[wsc_pkg::ADDR_W-2:0], spi_sdi};
    end
  end

  // read data are captured once the header is in, then shifted out on falling edges
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_shift <= '0;
      spi_sdo  <= 1'b0;
    end else if (!in_frame) begin
      spi_sdo  <= 1'b0;
    end else if (sclk_fall && bit_cnt == wsc_pkg::CNT_HEAD_DONE) begin
      spi_sdo  <= rd_data[W-1];
      tx_shift <= {rd_data[W-2:0], 1'b0};
    end else if (sclk_fall && bit_cnt > wsc_pkg::CNT_HEAD_DONE) begin
      spi_sdo  <= tx_shift[W-1];
      tx_shift <= {tx_shift[W-2:0], 1'b0};
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      spi_sdo_en <= 1'b0;
    end else begin
      spi_sdo_en <= in_frame;
    end
  end

  // write is committed when chip select returns high
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_wr  <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
    end else begin
      reg_wr  <= frame_write;
      wr_addr <= shift_in[wsc_pkg::FRAME_W-1:wsc_pkg::POS_ADDR_LSB];
      wr_data <= shift_in[W-1:0];
    end
  end

  // register bank
  logic [W-1:0] int_ctrl;
  logic [W-1:0] ext_ctrl;
  logic [W-1:0] pull_ctrl;
  logic         wr_int;
  logic         wr_ext;
  logic         wr_pull;

  assign wr_int  = reg_wr & (wr_addr == wsc_pkg::ADDR_INTERNAL_WAKE);
  assign wr_ext  = reg_wr & (wr_addr == wsc_pkg::ADDR_EXTERNAL_WAKE);
  assign wr_pull = reg_wr & (wr_addr == wsc_pkg::ADDR_PULL_CONTROL);

  // reserved bits are never stored, so the read path needs no masking
  assign rd_data = (frame_addr == wsc_pkg::ADDR_INTERNAL_WAKE) ? int_ctrl
                 : (frame_addr == wsc_pkg::ADDR_EXTERNAL_WAKE) ? ext_ctrl
                 : (frame_addr == wsc_pkg::ADDR_PULL_CONTROL)  ? pull_ctrl
                 :                                               wsc_pkg::READ_UNMAPPED;

  wsc_load_if #(.WIDTH(W)) int_load  ();
  wsc_load_if #(.WIDTH(W)) ext_load  ();
  wsc_load_if #(.WIDTH(W)) pull_load ();

  // priority: soft reset, then fail-safe or restart, then the watchdog update
  assign int_load.ld    = soft_reset_req | restart_entry | wd_off_update;
  assign int_load.mask  = soft_reset_req ? wsc_pkg::MASK_ALL
                        : restart_entry  ? wsc_pkg::RESTART_MASK_INTERNAL
                        : wd_off_update  ? (W'(1) << wsc_pkg::BIT_STOP_WD_OFF)
                        :                  wsc_pkg::MASK_NONE;
  assign int_load.value = soft_reset_req ? wsc_pkg::RST_INTERNAL
                        : restart_entry  ? wsc_pkg::RESTART_VAL_INTERNAL
                        :                  (W'(wd_off_value) << wsc_pkg::BIT_STOP_WD_OFF);

  assign ext_load.ld    = soft_reset_req | fail_safe_entry;
  assign ext_load.mask  = soft_reset_req ? wsc_pkg::MASK_ALL
                        :                  wsc_pkg::FAILSAFE_MASK_EXTERNAL;
  assign ext_load.value = soft_reset_req ? wsc_pkg::RST_EXTERNAL
                        :                  wsc_pkg::FAILSAFE_VAL_EXTERNAL;

  assign pull_load.ld    = soft_reset_req;
  assign pull_load.mask  = wsc_pkg::MASK_ALL;
  assign pull_load.value = wsc_pkg::RST_PULL;

  wsc_reg_cell #(
    .WIDTH       (W),
    .RESET_VALUE (wsc_pkg::RST_INTERNAL),
    .WRITE_MASK  (wsc_pkg::WMASK_INTERNAL)
  ) u_internal (
    .clk     (clk),
    .reset_n (reset_n),
    .wr      (wr_int),
    .wdata   (wr_data),
    .load    (int_load),
    .q       (int_ctrl)
  );

  wsc_reg_cell #(
    .WIDTH       (W),
    .RESET_VALUE (wsc_pkg::RST_EXTERNAL),
    .WRITE_MASK  (wsc_pkg::WMASK_EXTERNAL)
  ) u_external (
    .clk     (clk),
    .reset_n (reset_n),
    .wr      (wr_ext),
    .wdata   (wr_data),
    .load    (ext_load),
    .q       (ext_ctrl)
  );

  wsc_reg_cell #(
    .WIDTH       (W),
    .RESET_VALUE (wsc_pkg::RST_PULL),
    .WRITE_MASK  (wsc_pkg::WMASK_PULL)
  ) u_pull (
    .clk     (clk),
    .reset_n (reset_n),
    .wr      (wr_pull),
    .wdata   (wr_data),
    .load    (pull_load),
    .q       (pull_ctrl)
  );

  logic [2:0] wake_enable;

  wsc_wake_resolve #(
    .INPUTS (3)
  ) u_resolve (
    .clk            (clk),
    .reset_n        (reset_n),
    .ext_ctrl       (ext_ctrl),
    .normal_mode    (normal_mode),
    .wake_enable    (wake_enable),
    .measure_enable (measure_enable)
  );

  assign first_hv_wake_input_enable  = wake_enable[0];
  assign second_hv_wake_input_enable = wake_enable[1];
  assign third_hv_wake_input_enable  = wake_enable[2];

  // these come straight from the register flip-flops
  assign second_timer_wake_enable   = int_ctrl[wsc_pkg::BIT_SECOND_TIMER_WAKE];
  assign first_timer_wake_enable    = int_ctrl[wsc_pkg::BIT_FIRST_TIMER_WAKE];
  assign stop_mode_watchdog_off_bit = int_ctrl[wsc_pkg::BIT_STOP_WD_OFF];
  assign interrupt_scope_all        = ext_ctrl[wsc_pkg::BIT_INT_GLOBAL];
  assign first_input_pull_select    = pull_ctrl[wsc_pkg::POS_FIRST_PULL +: 2];
  assign second_input_pull_select   = pull_ctrl[wsc_pkg::POS_SECOND_PULL +: 2];
  assign third_input_pull_select    = pull_ctrl[wsc_pkg::POS_THIRD_PULL +: 2];

  // interrupt scope gate; the status registers themselves live elsewhere
  logic next_int_request;

  assign next_int_request = wake_event | (interrupt_scope_all & status_event);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      int_request <= 1'b0;
    end else begin
      int_request <= next_int_request;
    end
  end

  // bus transceiver modes stay owned by bus control; only the fail-safe
  // restore of its wake setting is requested from here
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_ctrl_force       <= 1'b0;
      bus_ctrl_force_value <= wsc_pkg::FAILSAFE_VAL_BUS;
    end else begin
      bus_ctrl_force       <= fail_safe_entry & ~soft_reset_req;
      bus_ctrl_force_value <= wsc_pkg::FAILSAFE_VAL_BUS;
    end
  end

endmodule

// ### tb/wsc_wake_config_properties.sv
/*
  Concurrent checks of the wake source configuration bank at its ports.
  Assumes one clock domain and the bind below into every bank instance.
*/
`timescale 1ns/1ns
module wsc_wake_config_properties (
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       soft_reset_req,
  input wire logic       restart_entry,
  input wire logic       fail_safe_entry,
  input wire logic       wd_off_update,
  input wire logic       wd_off_value,
  input wire logic       wake_event,
  input wire logic       status_event,
  input wire logic       second_timer_wake_enable,
  input wire logic       first_timer_wake_enable,
  input wire logic       stop_mode_watchdog_off_bit,
  input wire logic       interrupt_scope_all,
  input wire logic       first_hv_wake_input_enable,
  input wire logic       second_hv_wake_input_enable,
  input wire logic       third_hv_wake_input_enable,
  input wire logic       measure_enable,
  input wire logic       int_request,
  input wire logic       bus_ctrl_force,
  input wire logic [4:0] bus_ctrl_force_value
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_measure_blocks_wake: assert property (
    measure_enable |-> !first_hv_wake_input_enable && !second_hv_wake_input_enable)
    else $error("measurement active while first or second input wake enabled");
  // guarded by the previous reset level so the first edge sees no stale inputs
  a_int_scope_gate: assert property (
    $past(reset_n) |-> int_request == $past(wake_event || (interrupt_scope_all && status_event)))
    else $error("interrupt request does not match the scope gate");
  a_force_pulse: assert property (
    fail_safe_entry && !soft_reset_req |=> bus_ctrl_force && bus_ctrl_force_value == 5'h09)
    else $error("fail-safe entry gave no bus control force");
  a_force_cause: assert property (
    bus_ctrl_force |-> $past(fail_safe_entry))
    else $error("bus control force without fail-safe entry");
  a_failsafe_wakes: assert property (
    fail_safe_entry && !soft_reset_req |-> ##2 first_hv_wake_input_enable
      && second_hv_wake_input_enable && third_hv_wake_input_enable && !measure_enable)
    else $error("fail-safe entry did not restore the input wakes");
  a_restart_keeps: assert property (
    restart_entry && !soft_reset_req |=> !stop_mode_watchdog_off_bit
      && $stable(second_timer_wake_enable) && $stable(first_timer_wake_enable))
    else $error("restart changed timer enables or kept the watchdog bit");
  a_wd_hw_update: assert property (
    wd_off_update && !soft_reset_req && !restart_entry && !fail_safe_entry
      |=> stop_mode_watchdog_off_bit == $past(wd_off_value))
    else $error("hardware update of the watchdog bit lost");
  a_soft_clears: assert property (
    soft_reset_req |=> !second_timer_wake_enable && !first_timer_wake_enable
      && !stop_mode_watchdog_off_bit && !interrupt_scope_all ##1 first_hv_wake_input_enable
      && second_hv_wake_input_enable && third_hv_wake_input_enable)
    else $error("soft reset left wrong register values");
endmodule

bind wsc_wake_config wsc_wake_config_properties u_props (.clk, .reset_n, .soft_reset_req,
  .restart_entry, .fail_safe_entry, .wd_off_update, .wd_off_value, .wake_event,
  .status_event, .second_timer_wake_enable, .first_timer_wake_enable,
  .stop_mode_watchdog_off_bit, .interrupt_scope_all, .first_hv_wake_input_enable,
  .second_hv_wake_input_enable, .third_hv_wake_input_enable, .measure_enable,
  .int_request, .bus_ctrl_force, .bus_ctrl_force_value);

// ### tb/wsc_wake_config_bench.sv
/*
  Self-checking bench of the wake source configuration bank: serial
  register frames, hardware events and the derived enables.
  Assumes a 125 MHz clk and the property checker bound in separately.
*/
`timescale 1ns/1ns
module wsc_wake_config_bench;
  logic       clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       spi_csn_n = 1'b1, spi_clk = 1'b0, spi_sdi = 1'b0;
  logic       soft_reset_req = 1'b0, restart_entry = 1'b0, fail_safe_entry = 1'b0;
  logic       wd_off_update = 1'b0, wd_off_value = 1'b0, normal_mode = 1'b0;
  logic       wake_event = 1'b0, status_event = 1'b0;
  logic       spi_sdo, spi_sdo_en, second_timer_wake_enable, first_timer_wake_enable;
  logic       stop_mode_watchdog_off_bit, interrupt_scope_all, measure_enable;
  logic       first_hv_wake_input_enable, second_hv_wake_input_enable;
  logic       third_hv_wake_input_enable, int_request, bus_ctrl_force;
  logic [1:0] first_input_pull_select, second_input_pull_select, third_input_pull_select;
  logic [4:0] bus_ctrl_force_value;
  logic [7:0] q;
  logic       en_seen;
  int         miscompares = 0;
  int         checks_done = 0;

  always #4 clk = ~clk;

  wsc_wake_config dut (.clk, .reset_n, .spi_csn_n, .spi_clk, .spi_sdi, .spi_sdo,
    .spi_sdo_en, .soft_reset_req, .restart_entry, .fail_safe_entry, .wd_off_update,
    .wd_off_value, .normal_mode, .wake_event, .status_event, .second_timer_wake_enable,
    .first_timer_wake_enable, .stop_mode_watchdog_off_bit, .interrupt_scope_all,
    .first_hv_wake_input_enable, .second_hv_wake_input_enable,
    .third_hv_wake_input_enable, .measure_enable, .first_input_pull_select,
    .second_input_pull_select, .third_input_pull_select, .int_request,
    .bus_ctrl_force, .bus_ctrl_force_value);

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // three clk per serial level keeps well above the two-cycle minimum
  task automatic xfer(input logic [6:0] a, input logic rw, input logic [7:0] d);
    logic [15:0] f;
    f = {a, rw, d};
    spi_csn_n = 1'b0;
    tick(2);
    for (int i = 15; i >= 0; i--) begin
      spi_sdi = f[i];
      tick(3);
      spi_clk = 1'b1;
      tick(3);
      if (i < 8) q[i] = spi_sdo;
      if (i == 0) en_seen = spi_sdo_en;
      spi_clk = 1'b0;
    end
    tick(3);
    spi_csn_n = 1'b1;
    tick(6);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    xfer(a, 1'b1, d);
  endtask

  task automatic rdchk(input string name, input logic [6:0] a, input logic [7:0] exp);
    xfer(a, 1'b0, 8'h00);
    chk(name, exp, q);
    chk("sdo_en", 8'h01, {7'b0000000, en_seen});
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
    tick(3);
  endtask

  function automatic logic [7:0] outs();
    return {second_timer_wake_enable, first_timer_wake_enable, stop_mode_watchdog_off_bit,
      interrupt_scope_all, first_hv_wake_input_enable, second_hv_wake_input_enable,
      third_hv_wake_input_enable, measure_enable};
  endfunction

  function automatic logic [7:0] pulls();
    return {2'b00, third_input_pull_select, second_input_pull_select,
      first_input_pull_select};
  endfunction

  task automatic t_reset();
    rdchk("internal", 7'h06, 8'h00);
    rdchk("external", 7'h07, 8'h07);
    rdchk("pull", 7'h08, 8'h00);
    rdchk("unmapped", 7'h20, 8'h00);
    chk("outs", 8'h0e, outs());
    chk("sdo_en_idle", 8'h00, {7'b0000000, spi_sdo_en});
  endtask

  task automatic t_write_all();
    normal_mode = 1'b1;
    wr(7'h06, 8'hff);
    wr(7'h07, 8'hff);
    wr(7'h08, 8'hff);
    chk("force", 8'h00, {7'b0000000, bus_ctrl_force});
    rdchk("internal", 7'h06, 8'hc4);
    rdchk("external", 7'h07, 8'ha7);
    rdchk("pull", 7'h08, 8'h3f);
    chk("outs", 8'hf3, outs());
    chk("pulls", 8'h3f, pulls());
    wr(7'h06, 8'h80);
    chk("outs", 8'h93, outs());
    wr(7'h06, 8'h40);
    chk("outs", 8'h53, outs());
  endtask

  task automatic t_wake();
    logic [2:0] v;
    normal_mode = 1'b0;
    for (int i = 0; i < 8; i++) begin
      v = 3'(i);
      wr(7'h07, {5'b00000, v});
      chk("outs", {4'h4, v[0], v[1], v[2], 1'b0}, outs());
    end
    wr(7'h07, 8'h27);
    chk("outs", 8'h42, outs());
    normal_mode = 1'b1;
    tick(2);
    chk("outs", 8'h43, outs());
  endtask

  task automatic t_pull();
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      c = 2'(i);
      wr(7'h08, {2'b00, c, 2'(c + 1), 2'(c + 2)});
      chk("pulls", {2'b00, c, 2'(c + 1), 2'(c + 2)}, pulls());
    end
  endtask

  task automatic t_hw_events();
    wr(7'h06, 8'hc4);
    pulse(restart_entry);
    rdchk("internal", 7'h06, 8'hc0);
    wd_off_value = 1'b1;
    pulse(wd_off_update);
    rdchk("internal", 7'h06, 8'hc4);
    wd_off_value = 1'b0;
    pulse(wd_off_update);
    rdchk("internal", 7'h06, 8'hc0);
  endtask

  task automatic t_failsafe();
    wr(7'h07, 8'ha0);
    fail_safe_entry = 1'b1;
    tick(1);
    fail_safe_entry = 1'b0;
    chk("force", 8'h01, {7'b0000000, bus_ctrl_force});
    chk("force_value", 8'h09, {3'b000, bus_ctrl_force_value});
    tick(1);
    chk("force", 8'h00, {7'b0000000, bus_ctrl_force});
    rdchk("external", 7'h07, 8'h87);
    chk("outs", 8'hde, outs());
  endtask

  task automatic t_int();
    status_event = 1'b1;
    tick(1);
    chk("int", 8'h01, {7'b0000000, int_request});
    status_event = 1'b0;
    wr(7'h07, 8'h07);
    status_event = 1'b1;
    tick(1);
    chk("int", 8'h00, {7'b0000000, int_request});
    status_event = 1'b0;
    wake_event = 1'b1;
    tick(1);
    chk("int", 8'h01, {7'b0000000, int_request});
    wake_event = 1'b0;
  endtask

  task automatic t_soft();
    wr(7'h08, 8'h15);
    wr(7'h07, 8'ha0);
    pulse(soft_reset_req);
    rdchk("internal", 7'h06, 8'h00);
    rdchk("external", 7'h07, 8'h07);
    rdchk("pull", 7'h08, 8'h00);
  endtask

  task automatic end_of_test();
    $display("checks_done %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    tick(20);
    reset_n = 1'b1;
    tick(2);
    t_reset();
    t_write_all();
    t_wake();
    t_pull();
    t_hw_events();
    t_failsafe();
    t_int();
    t_soft();
    end_of_test();
  end

  // the whole sequence needs about four thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_of_test();
  end
endmodule
